// [logic/ifvm_core.sv]
// interrupt pending flags, vector address selection and register port
`timescale 1ns/1ps
module ifvm_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // peripheral request pulses
    input wire ifvm_pkg::ifvm_src_t src_req,
    // vector fetch from the cpu core
    input wire logic vec_fetch,
    input wire ifvm_pkg::ifvm_fetch_t fetch_kind,
    output ifvm_pkg::ifvm_vec_t vec_out,
    output logic cpu_irq_pending,
    // register port
    input wire ifvm_pkg::ifvm_bus_t bus,
    output logic [7:0] rdata,
    // event interrupt
    output logic irq
);
    import ifvm_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // index of the highest priority set bit, none when empty
    function automatic logic [2:0] top_src(input logic [5:0] p);
        logic [2:0] r;
        r = SRC_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // vector high-byte address for a source index
    function automatic logic [15:0] vec_of(input logic [2:0] s);
        logic [15:0] a;
        a = VEC_RESET;
        unique case (s)
            SRC_EXT: a = VEC_EXT;
            SRC_CH0: a = VEC_CH0;
            SRC_CH1: a = VEC_CH1;
            SRC_WRAP: a = VEC_WRAP;
            SRC_KEY: a = VEC_KEY;
            SRC_CONV: a = VEC_CONV;
            default: a = VEC_RESET;
        endcase
        return a;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [5:0] pending;
    logic [5:0] req_vec;
    logic [5:0] clr_vec;
    logic [2:0] winner;
    logic irq_fetch;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic [7:0] evt_set;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] flags_c;
    logic [7:0] next_rdata;

    assign req_vec = src_req;

    // ------------------------------------------------------------
    // pending flags and arbitration
    // ------------------------------------------------------------

    assign winner = top_src(pending);
    assign irq_fetch = vec_fetch && (fetch_kind == IFVM_FETCH_IRQ);

    // one flag per source; a new request beats the fetch clear
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_pend
            assign clr_vec[gi] = irq_fetch && (winner == 3'(gi));
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pending[gi] <= RST_PEND[gi];
                end else if (req_vec[gi]) begin
                    pending[gi] <= 1'b1;
                end else if (clr_vec[gi]) begin
                    pending[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign cpu_irq_pending = |pending;

    // ------------------------------------------------------------
    // vector answer
    // ------------------------------------------------------------

    // answer one cycle after the fetch, reset above swi above sources
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vec_out <= '0;
        end else if (vec_fetch) begin
            vec_out.valid <= 1'b1;
            unique case (fetch_kind)
                IFVM_FETCH_RESET: begin
                    vec_out.spurious <= 1'b0;
                    vec_out.source <= SRC_NONE;
                    vec_out.hi_addr <= VEC_RESET;
                    vec_out.lo_addr <= VEC_RESET + 16'h0001;
                end
                IFVM_FETCH_SWI: begin
                    vec_out.spurious <= 1'b0;
                    vec_out.source <= SRC_NONE;
                    vec_out.hi_addr <= VEC_SWI;
                    vec_out.lo_addr <= VEC_SWI + 16'h0001;
                end
                default: begin
                    vec_out.spurious <= (winner == SRC_NONE);
                    vec_out.source <= winner;
                    vec_out.hi_addr <= vec_of(winner);
                    vec_out.lo_addr <= vec_of(winner) + 16'h0001;
                end
            endcase
        end else begin
            vec_out.valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // flag register images
    // ------------------------------------------------------------

    always_comb begin
        flags_a = RST_FLAGS;
        flags_a[POS_A_WRAP] = pending[SRC_WRAP];
        flags_a[POS_A_CH1] = pending[SRC_CH1];
        flags_a[POS_A_CH0] = pending[SRC_CH0];
        flags_a[POS_A_EXT] = pending[SRC_EXT];
    end

    always_comb begin
        flags_b = RST_FLAGS;
        flags_b[POS_B_KEY] = pending[SRC_KEY];
    end

    always_comb begin
        flags_c = RST_FLAGS;
        flags_c[POS_C_CONV] = pending[SRC_CONV];
    end

    // ------------------------------------------------------------
    // event status, mask and interrupt line
    // ------------------------------------------------------------

    // source requests and vector deliveries raise events
    always_comb begin
        evt_set = RST_EVT;
        evt_set[5:0] = req_vec;
        evt_set[POS_EVT_VEC] = vec_out.valid;
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_status <= RST_EVT;
        end else if (bus.wr && bus.addr == OFS_EVT_STATUS) begin
            evt_status <= (evt_status & ~bus.wdata) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    // mask register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_mask <= RST_MASK;
        end else if (bus.wr && bus.addr == OFS_EVT_MASK) begin
            evt_mask <= bus.wdata;
        end
    end

    assign irq = |(evt_status & evt_mask);

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------

    // flag registers ignore writes, unmapped read zero
    always_comb begin
        unique case (bus.addr)
            OFS_FLAGS_A: next_rdata = flags_a;
            OFS_FLAGS_B: next_rdata = flags_b;
            OFS_FLAGS_C: next_rdata = flags_c;
            OFS_EVT_STATUS: next_rdata = evt_status;
            OFS_EVT_MASK: next_rdata = evt_mask;
            default: next_rdata = 8'h00;
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // ifvm_core

// [logic/ifvm_pkg.sv]
// constants, field layouts and carrier types of the interrupt flag and vector block
// Notes on behaviour
// - conversion done is lowest priority; vector bytes at FFDE and FFDF.
// - timer wrap vector bytes come from FFF2 and FFF3.
// - timer channel 1 vector bytes come from FFF4 and FFF5.
// - timer channel 0 vector bytes come from FFF6 and FFF7.
// - flags A shows wrap, ch1, ch0, ext pin in bits 6,5,4,2; read-only.
// - flags B shows keypad in bit 7; read-only, reset zero; vector FFE0.
// - flags C shows conversion done in bit 0; read-only, reset zero.
package ifvm_pkg;

    // ------------------------------------------------------------
    // source indices, rising index means falling priority
    // ------------------------------------------------------------
    localparam int NSRC = 6;
    localparam logic [2:0] SRC_EXT = 3'h0;
    localparam logic [2:0] SRC_CH0 = 3'h1;
    localparam logic [2:0] SRC_CH1 = 3'h2;
    localparam logic [2:0] SRC_WRAP = 3'h3;
    localparam logic [2:0] SRC_KEY = 3'h4;
    localparam logic [2:0] SRC_CONV = 3'h5;
    localparam logic [2:0] SRC_NONE = 3'h7;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_FLAGS_A = 16'hFE04;
    localparam logic [15:0] OFS_FLAGS_B = 16'hFE05;
    localparam logic [15:0] OFS_FLAGS_C = 16'hFE06;
    localparam logic [15:0] OFS_EVT_STATUS = 16'hFE08;
    localparam logic [15:0] OFS_EVT_MASK = 16'hFE09;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int POS_A_WRAP = 6;
    localparam int POS_A_CH1 = 5;
    localparam int POS_A_CH0 = 4;
    localparam int POS_A_EXT = 2;
    localparam int POS_B_KEY = 7;
    localparam int POS_C_CONV = 0;
    localparam int POS_EVT_VEC = 6;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_EVT = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [5:0] RST_PEND = 6'h00;

    // ------------------------------------------------------------
    // vector high-byte addresses, low byte sits one above
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_CONV = 16'hFFDE;
    localparam logic [15:0] VEC_KEY = 16'hFFE0;
    localparam logic [15:0] VEC_WRAP = 16'hFFF2;
    localparam logic [15:0] VEC_CH1 = 16'hFFF4;
    localparam logic [15:0] VEC_CH0 = 16'hFFF6;
    localparam logic [15:0] VEC_EXT = 16'hFFFA;
    localparam logic [15:0] VEC_SWI = 16'hFFFC;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IFVM_FETCH_RESET,
        IFVM_FETCH_SWI,
        IFVM_FETCH_IRQ
    } ifvm_fetch_t;

    typedef struct packed {
        logic conversion_done;
        logic keypad;
        logic timer_wrap;
        logic timer_ch1;
        logic timer_ch0;
        logic ext_pin;
    } ifvm_src_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ifvm_bus_t;

    typedef struct packed {
        logic valid;
        logic spurious;
        logic [2:0] source;
        logic [15:0] hi_addr;
        logic [15:0] lo_addr;
    } ifvm_vec_t;

endpackage

// [testbench/ifvm_core_sva.sv]
// checker for vector fetch and register read timing
`timescale 1ns/1ps
module ifvm_core_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports
    input wire ifvm_pkg::ifvm_src_t src_req,
    input wire logic vec_fetch,
    input wire ifvm_pkg::ifvm_fetch_t fetch_kind,
    input wire ifvm_pkg::ifvm_vec_t vec_out,
    input wire logic cpu_irq_pending,
    input wire ifvm_pkg::ifvm_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    import ifvm_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // fetch answer and vector table
    a_valid_after_fetch: assert property (vec_fetch |=> vec_out.valid)
        else $error("valid missing after fetch");
    a_no_stray_valid: assert property (!vec_fetch |=> !vec_out.valid)
        else $error("valid without fetch");
    a_lo_pairs_hi: assert property (vec_out.valid |-> vec_out.lo_addr == vec_out.hi_addr + 16'h1)
        else $error("low byte address not next to high");
    a_conv_vec_addr: assert property (vec_out.valid && vec_out.source == SRC_CONV
        |-> vec_out.hi_addr == 16'hFFDE) else $error("conversion vector wrong");
    a_wrap_vec_addr: assert property (vec_out.valid && vec_out.source == SRC_WRAP
        |-> vec_out.hi_addr == 16'hFFF2) else $error("wrap vector wrong");
    a_ch1_vec_addr: assert property (vec_out.valid && vec_out.source == SRC_CH1
        |-> vec_out.hi_addr == 16'hFFF4) else $error("ch1 vector wrong");
    a_ch0_vec_addr: assert property (vec_out.valid && vec_out.source == SRC_CH0
        |-> vec_out.hi_addr == 16'hFFF6) else $error("ch0 vector wrong");
    a_ext_vec_addr: assert property (vec_out.valid && vec_out.source == SRC_EXT
        |-> vec_out.hi_addr == 16'hFFFA) else $error("ext pin vector wrong");
    a_key_vec_addr: assert property (vec_out.valid && vec_out.source == SRC_KEY
        |-> vec_out.hi_addr == 16'hFFE0) else $error("keypad vector wrong");
    a_spurious_fetch: assert property (vec_fetch && fetch_kind == IFVM_FETCH_IRQ
        && !cpu_irq_pending |=> vec_out.spurious && vec_out.hi_addr == 16'hFFFE)
        else $error("empty fetch not spurious");
    // unused flag bits read zero
    a_flags_a_zero: assert property (bus.rd && bus.addr == 16'hFE04
        |=> (rdata & 8'h8B) == 8'h00) else $error("flags a unused bit set");
    a_flags_b_zero: assert property (bus.rd && bus.addr == 16'hFE05
        |=> rdata[6:0] == 7'h00) else $error("flags b unused bit set");
    a_flags_c_zero: assert property (bus.rd && bus.addr == 16'hFE06
        |=> rdata[7:1] == 7'h00) else $error("flags c unused bit set");
    c_spurious: cover property (vec_out.valid && vec_out.spurious);
    c_conv: cover property (vec_out.valid && vec_out.source == SRC_CONV);
    c_irq: cover property (irq);
endmodule // ifvm_core_sva

// [testbench/ifvm_cpu_model.sv]
// cpu core model that strobes vector fetches
`timescale 1ns/1ps
module ifvm_cpu_model (
    // clock
    input wire logic sys_clk,
    // command from the bench
    input wire logic go,
    input wire ifvm_pkg::ifvm_fetch_t kind,
    // fetch strobe toward the block
    output ifvm_pkg::ifvm_fetch_t fetch_kind,
    output logic vec_fetch
);
    import ifvm_pkg::*;
    initial begin
        vec_fetch = 1'b0;
        fetch_kind = IFVM_FETCH_RESET;
    end
    always @(posedge sys_clk) begin
        vec_fetch <= go;
        fetch_kind <= go ? kind : ifvm_fetch_t'(fetch_kind + 2'h1); // wander while idle
    end
endmodule // ifvm_cpu_model

// [testbench/interrupt_flag_vector_map_tb_top.sv]
// bench top: random requests, flag reads and vector fetches
`timescale 1ns/1ps
module interrupt_flag_vector_map_tb_top;
    import ifvm_pkg::*;
    localparam logic [15:0] VT [6] = '{VEC_EXT, VEC_CH0, VEC_CH1, VEC_WRAP, VEC_KEY, VEC_CONV};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    ifvm_fetch_t kind = IFVM_FETCH_IRQ;
    ifvm_src_t src_req = '0;
    ifvm_bus_t bus = '0;
    ifvm_fetch_t fetch_kind;
    ifvm_vec_t vec_out;
    logic vec_fetch;
    logic cpu_irq_pending;
    logic irq;
    logic [7:0] rdata;
    logic [5:0] pend = 6'h00;
    logic [31:0] seed = 32'h05D9;
    int fails = 0;
    int checks = 0;
    always #25 sys_clk = ~sys_clk;
    ifvm_core i_ifvm_core (.sys_clk(sys_clk), .rst(rst), .src_req(src_req),
        .vec_fetch(vec_fetch), .fetch_kind(fetch_kind), .vec_out(vec_out),
        .cpu_irq_pending(cpu_irq_pending), .bus(bus), .rdata(rdata), .irq(irq));
    ifvm_cpu_model i_ifvm_cpu_model (.sys_clk(sys_clk), .go(go), .kind(kind),
        .fetch_kind(fetch_kind), .vec_fetch(vec_fetch));
    // next random word
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // highest pending source, none when empty
    function automatic logic [2:0] top_src(input logic [5:0] p);
        top_src = SRC_NONE;
        for (int i = 5; i >= 0; i--) if (p[i]) top_src = 3'(i);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one register access, q holds read data
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge sys_clk);
        bus <= '{w, !w, a, d};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        q = rdata;
    endtask
    task automatic req(input logic [5:0] r);
        @(posedge sys_clk);
        src_req <= r;
        @(posedge sys_clk);
        src_req <= '0;
        pend = pend | r;
        #1;
    endtask
    task automatic fetch(input ifvm_fetch_t k, input logic [15:0] hi);
        @(posedge sys_clk);
        go <= 1'b1;
        kind <= k;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(16'(vec_out.valid), 16'h1);
        chk(vec_out.hi_addr, hi);
        chk(vec_out.lo_addr, hi + 16'h1);
    endtask
    task automatic irq_fetch;
        logic [2:0] s;
        s = top_src(pend);
        chk(16'(cpu_irq_pending), 16'(pend != 6'h00));
        fetch(IFVM_FETCH_IRQ, (s == SRC_NONE) ? VEC_RESET : VT[s]);
        chk(16'(vec_out.source), 16'(s));
        chk(16'(vec_out.spurious), 16'(s == SRC_NONE));
        if (s != SRC_NONE) pend[s] = 1'b0;
    endtask
    task automatic chk_flags;
        logic [7:0] q;
        acc(1'b0, OFS_FLAGS_A, 8'h00, q);
        chk(16'(q), 16'({1'b0, pend[3:1], 1'b0, pend[0], 2'b00}));
        acc(1'b0, OFS_FLAGS_B, 8'h00, q);
        chk(16'(q), 16'({pend[4], 7'h00}));
        acc(1'b0, OFS_FLAGS_C, 8'h00, q);
        chk(16'(q), 16'({7'h00, pend[5]}));
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        print_verdict();
    end
    initial begin
        logic [7:0] q;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        // writes to flag registers and the reserved place change nothing
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 16'hFE04 + 16'(k), 8'hFF, q);
            acc(1'b0, 16'hFE04 + 16'(k), 8'h00, q);
            chk(16'(q), 16'h0);
        end
        $display("test read-only done");
        // event interrupt: mask, raise, clear
        acc(1'b1, OFS_EVT_MASK, 8'h02, q);
        req(6'h01);
        chk(16'(irq), 16'h0);
        req(6'h02);
        chk(16'(irq), 16'h1);
        acc(1'b1, OFS_EVT_STATUS, 8'h02, q);
        chk(16'(irq), 16'h0);
        acc(1'b0, OFS_EVT_STATUS, 8'h00, q);
        chk(16'(q), 16'h01);
        $display("test interrupt done");
        // all sources at once drain in priority order, then spurious
        req(6'h3F);
        repeat (8) irq_fetch();
        $display("test priority done");
        repeat (40) begin
            seed = lfsr(seed);
            req(seed[5:0] & {6{seed[8]}});
            chk_flags();
            irq_fetch();
        end
        $display("test random done");
        fetch(IFVM_FETCH_RESET, VEC_RESET);
        fetch(IFVM_FETCH_SWI, VEC_SWI);
        // delivered vectors leave their mark in the event status
        acc(1'b0, OFS_EVT_STATUS, 8'h00, q);
        chk(16'(q[POS_EVT_VEC]), 16'h1);
        $display("test fetch kinds done");
        print_verdict();
    end
endmodule // interrupt_flag_vector_map_tb_top
bind ifvm_core ifvm_core_sva i_ifvm_core_sva (.sys_clk(sys_clk), .rst(rst), .src_req(src_req),
    .vec_fetch(vec_fetch), .fetch_kind(fetch_kind), .vec_out(vec_out),
    .cpu_irq_pending(cpu_irq_pending), .bus(bus), .rdata(rdata), .irq(irq));
